/* design/sahp_pkg.sv */
// package for the parallel host port of a 12-bit sar converter
// assumes: one 50 MHz clock, host strobes arrive asynchronously on pins
// Overview of operation
// R1: completion flag goes low when a conversion finished and result is ready
// R2: with chip select low, read strobe falling edge drives result on bus
// R3: internal acquisition: write rising edge latches config, acquires, then converts
// R4: external acquisition: first write rising edge ends acquisition, starts conversion; code starts acquisition on first write, ends it on second
// R5: host supplies free clock in external clock mode, fixed level otherwise
// R6: chip select high puts completion flag and all data lines in high impedance
// R7: each sample is a twelve-bit successive-approximation result, in parallel
// R8: two power bits pick full/standby power-down, internal or external clock
// R9: config bit five picks internal (0) or external (1) acquisition
// R10: internal acquisition: host keeps write high until first conversion clock fall
// R11: low eight data lines bidirectional, upper four output only
// R12: completion flag returns high once the host starts a read
package sahp_pkg;
  localparam int RES_BITS = 12;
  localparam int CFG_BITS = 8;
  localparam int ACQ_MODE_BIT = 5;
  localparam int PWR_HI_BIT = 7;
  localparam int PWR_LO_BIT = 6;
  localparam logic [1:0] PWR_FULL_DOWN = 2'h0;
  localparam logic [1:0] PWR_STANDBY = 2'h1;
  localparam logic [1:0] PWR_INT_CLK = 2'h2;
  localparam logic [1:0] PWR_EXT_CLK = 2'h3;
  localparam logic [7:0] CFG_RESET = 8'h80;
  localparam int INT_CLK_DIV = 7;
  localparam int ACQ_CYCLES = 3;
  typedef enum logic [1:0] {SAHP_IDLE, SAHP_ACQ, SAHP_CONV} sahp_state_t;
endpackage

/* design/sahp_port.sv */
// parallel host port: strobe decode, config byte, sar sequencer, bus drivers
// assumes: host pins are async and synchronised here; comparator bit is an input
module sahp_port
  import sahp_pkg::*;
(
  // clock and reset
  input wire logic clk,
  input wire logic rst,
  // host strobes
  input wire logic cs_n,
  input wire logic rd_n,
  input wire logic wr_n,
  input wire logic conv_clk,
  // data bus pins
  input wire logic [sahp_pkg::CFG_BITS-1:0] data_in,
  output logic [sahp_pkg::RES_BITS-1:0] data_out,
  output logic [sahp_pkg::RES_BITS-1:0] data_oe,
  // completion flag pin
  output logic done_n_out,
  output logic done_n_oe,
  // analog side
  input wire logic cmp_in,
  output logic [sahp_pkg::RES_BITS-1:0] dac_code,
  output logic track,
  output logic [sahp_pkg::CFG_BITS-1:0] config_byte
);
  import sahp_pkg::*;

  logic [3:0] s1_r, s2_r, s3_r;
  always_ff @(posedge clk or posedge rst)
    if (rst)
    begin
      // conv_clk parks low when unused; matching that here avoids a false fall after reset
      s1_r <= 4'he;
      s2_r <= 4'he;
      s3_r <= 4'he;
    end
    else
    begin
      s1_r <= {cs_n, rd_n, wr_n, conv_clk};
      s2_r <= s1_r;
      s3_r <= s2_r;
    end

  // synchronised views: [3]=cs_n [2]=rd_n [1]=wr_n [0]=conv_clk
  logic cs_lo, rd_fall, rd_lo, wr_rise, cclk_fall;
  assign cs_lo = !s2_r[3];
  assign rd_fall = cs_lo && s3_r[2] && !s2_r[2];
  assign rd_lo = cs_lo && !s2_r[2];
  assign wr_rise = cs_lo && !s3_r[1] && s2_r[1];
  assign cclk_fall = s3_r[0] && !s2_r[0];

  logic [7:0] din1_r, din2_r;
  always_ff @(posedge clk or posedge rst)
    if (rst)
    begin
      din1_r <= 8'h00;
      din2_r <= 8'h00;
    end
    else
    begin
      din1_r <= data_in;
      din2_r <= din1_r;
    end

  // power-down codes keep the previous clock mode
  logic [7:0] cfg_r;
  logic ext_clk_r;
  sahp_state_t st_r;
  always_ff @(posedge clk or posedge rst)
    if (rst)
    begin
      cfg_r <= CFG_RESET;
      ext_clk_r <= 1'b0;
    end
    else if (wr_rise && !(cfg_r[ACQ_MODE_BIT] && st_r == SAHP_ACQ))
    begin
      cfg_r <= din2_r;
      if (din2_r[PWR_HI_BIT]) // R8
        ext_clk_r <= din2_r[PWR_LO_BIT];
    end

  logic [1:0] pwr;
  logic run_ok;
  assign pwr = cfg_r[PWR_HI_BIT:PWR_LO_BIT];
  assign run_ok = pwr == PWR_INT_CLK || pwr == PWR_EXT_CLK;

  // internal clock divider; tick chosen by clock mode
  logic [3:0] div_r;
  always_ff @(posedge clk or posedge rst)
    if (rst)
      div_r <= 4'h0;
    else if (div_r == 4'(INT_CLK_DIV - 1))
      div_r <= 4'h0;
    else
      div_r <= div_r + 4'h1;
  logic tick;
  assign tick = ext_clk_r ? cclk_fall : (div_r == 4'(INT_CLK_DIV - 1)); // R5

  logic [3:0] bit_r;
  logic [1:0] acq_r;
  logic [11:0] sar_r, result_r;
  logic done_r;
  logic conv_end;
  assign conv_end = st_r == SAHP_CONV && tick && bit_r == 4'h0;

  always_ff @(posedge clk or posedge rst)
    if (rst)
    begin
      st_r <= SAHP_IDLE;
      bit_r <= 4'h0;
      acq_r <= 2'h0;
      sar_r <= 12'h000;
    end
    else
      unique case (st_r)
        SAHP_IDLE:
          if (wr_rise && din2_r[PWR_HI_BIT])
          begin
            st_r <= SAHP_ACQ;
            acq_r <= 2'h0;
          end
        SAHP_ACQ:
          if (!cfg_r[ACQ_MODE_BIT]) // R9
          begin
            if (tick) // R3 R10
            begin
              acq_r <= acq_r + 2'h1;
              if (acq_r == 2'(ACQ_CYCLES - 1))
              begin
                st_r <= SAHP_CONV;
                bit_r <= 4'(RES_BITS - 1);
                sar_r <= 12'h800;
              end
            end
          end
          else if (wr_rise) // R4
          begin
            st_r <= SAHP_CONV;
            bit_r <= 4'(RES_BITS - 1);
            sar_r <= 12'h800;
          end
        SAHP_CONV:
          if (!run_ok)
            st_r <= SAHP_IDLE;
          else if (tick) // R7
          begin
            sar_r[bit_r] <= cmp_in;
            if (bit_r == 4'h0)
              st_r <= SAHP_IDLE;
            else
            begin
              sar_r[bit_r - 4'h1] <= 1'b1;
              bit_r <= bit_r - 4'h1;
            end
          end
      endcase

  // set wins over the read that clears the flag
  always_ff @(posedge clk or posedge rst)
    if (rst)
    begin
      result_r <= 12'h000;
      done_r <= 1'b0;
    end
    else if (conv_end)
    begin
      result_r <= {sar_r[11:1], cmp_in};
      done_r <= 1'b1; // R1
    end
    else if (rd_fall)
      done_r <= 1'b0; // R12

  always_ff @(posedge clk or posedge rst)
    if (rst)
    begin
      data_out <= 12'h000;
      data_oe <= 12'h000;
      done_n_out <= 1'b1;
      done_n_oe <= 1'b0;
      dac_code <= 12'h000;
      track <= 1'b0;
      config_byte <= CFG_RESET;
    end
    else
    begin
      data_out <= result_r;
      data_oe <= {12{rd_lo}}; // R2 R6 R11
      done_n_out <= !done_r;
      done_n_oe <= cs_lo; // R6
      dac_code <= sar_r;
      track <= st_r == SAHP_ACQ;
      config_byte <= cfg_r;
    end

  sequence rd_edge_s;
    rd_fall;
  endsequence
  sequence flag_up_s;
    ##1 !done_r;
  endsequence
  read_clears_a: assert property (@(posedge clk) disable iff (rst) (rd_edge_s and !conv_end) |-> flag_up_s) // R12
    else $error("read did not clear flag");
  end_sets_a: assert property (@(posedge clk) disable iff (rst) conv_end |=> done_r ##1 !done_n_out) // R1
    else $error("flag not set after conversion");
  cs_float_a: assert property (@(posedge clk) disable iff (rst) s2_r[3] |=> !done_n_oe && data_oe == 12'h000) // R6
    else $error("outputs driven while deselected");
  read_drive_a: assert property (@(posedge clk) disable iff (rst) rd_fall |=> data_oe == 12'hfff) // R2
    else $error("read did not drive bus");
  ext_start_a: assert property (@(posedge clk) disable iff (rst)
    st_r == SAHP_ACQ && cfg_r[ACQ_MODE_BIT] && wr_rise |=> st_r == SAHP_CONV) // R4
    else $error("external acquisition not ended by write");
  int_start_a: assert property (@(posedge clk) disable iff (rst)
    st_r == SAHP_IDLE && wr_rise && din2_r[PWR_HI_BIT] |=> st_r == SAHP_ACQ) // R3
    else $error("write did not start acquisition");
  conv_bits_a: assert property (@(posedge clk) disable iff (rst)
    $rose(st_r == SAHP_CONV) |-> bit_r == 4'(RES_BITS - 1)) // R7
    else $error("conversion not twelve bits");
  pd_keep_a: assert property (@(posedge clk) disable iff (rst)
    wr_rise && !din2_r[PWR_HI_BIT] |=> $stable(ext_clk_r)) // R8
    else $error("power-down changed clock mode");
  acq_sel_a: assert property (@(posedge clk) disable iff (rst)
    st_r == SAHP_ACQ && !cfg_r[ACQ_MODE_BIT] && !tick |=> st_r == SAHP_ACQ) // R9
    else $error("internal acquisition left early");
  acq_track_a: assert property (@(posedge clk) disable iff (rst) st_r == SAHP_ACQ |=> track) // R3
    else $error("track low during acquisition");
endmodule

/* sim/sahp_host_model.sv */
// host-side model: conversion clock source and comparator stand-in
// assumes: a trial code at or below the held sample keeps its bit
module sahp_host_model
(
  // control
  input wire logic run,
  input wire logic [11:0] sample,
  // converter side
  input wire logic [11:0] dac_code,
  output logic conv_clk,
  output logic cmp_in
);
  timeunit 1ns;
  timeprecision 1ns;
  initial conv_clk = 1'b0;
  // free-running only in external clock mode, parked low otherwise
  always #80 conv_clk = run ? ~conv_clk : 1'b0;
  assign cmp_in = (dac_code <= sample);
endmodule

/* sim/tb_top.sv */
// testbench for the parallel host port: strobe tasks and conversion tests
// assumes: 50 MHz clk, strobes changed only just after rising edges
module tb_top;
  timeunit 1ns;
  timeprecision 1ns;
  import sahp_pkg::*;
  logic clk = 1'b0;
  logic rst = 1'b1;
  logic cs_n = 1'b1;
  logic rd_n = 1'b1;
  logic wr_n = 1'b1;
  logic run = 1'b0;
  logic [7:0] din = 8'h00;
  logic [11:0] smp = 12'h0a5c;
  logic conv_clk, cmp_in, dn, dnoe, track;
  logic [11:0] dout, doe, dac;
  logic [7:0] cfg;
  int miscompares = 0;
  int total_checks = 0;
  logic [7:0] cfgs [2] = '{8'h80, 8'hc0};
  logic [11:0] smps [2] = '{12'h0a5c, 12'h0fff};
  always #10 clk = ~clk;
  sahp_port sahp_port_inst(.clk(clk), .rst(rst), .cs_n(cs_n), .rd_n(rd_n), .wr_n(wr_n),
    .conv_clk(conv_clk), .data_in(din), .data_out(dout), .data_oe(doe), .done_n_out(dn),
    .done_n_oe(dnoe), .cmp_in(cmp_in), .dac_code(dac), .track(track), .config_byte(cfg));
  sahp_host_model sahp_host_model_inst(.run(run), .sample(smp), .dac_code(dac),
    .conv_clk(conv_clk), .cmp_in(cmp_in));
  task chk(input logic [11:0] seen, input logic [11:0] exp, input string m);
    total_checks++;
    if (seen !== exp)
    begin
      miscompares++;
      $display("unexpected %0t %s", $time, m);
    end
  endtask
  task cyc(input int n);
    repeat (n) @(posedge clk);
  endtask
  // strobes are synchronised inside, so each level is held several clocks
  task wr(input logic [7:0] b);
    @(posedge clk);
    cs_n <= 1'b0;
    wr_n <= 1'b0;
    din <= b;
    cyc(4);
    wr_n <= 1'b1;
    // one extra clock so registered outputs show the new state
    cyc(5);
  endtask
  task wait_done;
    for (int i = 0; i < 4000 && dn !== 1'b0; i++) @(posedge clk);
    chk(12'(dn), 12'h000, "no completion");
  endtask
  task rd;
    rd_n <= 1'b0;
    cyc(6);
    chk(doe, 12'hfff, "bus not driven");
    chk(dout, smp, "wrong result");
    rd_n <= 1'b1;
    cyc(6);
    chk(12'(dn), 12'h001, "flag not cleared");
  endtask
  task idle;
    cs_n <= 1'b1;
    cyc(6);
    chk(doe, 12'h000, "bus still driven");
    chk(12'(dnoe), 12'h000, "flag still driven");
  endtask
  task summarize;
    $display("checks %0d mismatches %0d", total_checks, miscompares);
    if (miscompares == 0 && total_checks > 0)
      $display("ALL CHECKS OK");
    else
      $display("CHECKS NOT OK");
    $finish;
  endtask
  // about 1000 cycles expected; the limit leaves wide margin
  initial
  begin
    #200us;
    miscompares++;
    summarize();
  end
  initial
  begin
    cyc(3);
    chk(12'(cfg), 12'(CFG_RESET), "reset config");
    chk(doe, 12'h000, "bus in reset");
    rst <= 1'b0;
    cyc(2);
    for (int k = 0; k < 2; k++)
    begin
      smp <= smps[k];
      run <= cfgs[k][6];
      wr(cfgs[k]);
      wait_done();
      chk(12'(cfg), 12'(cfgs[k]), "config not latched");
      rd();
      idle();
      $display("test normal %0d done", k);
    end
    run <= 1'b0;
    smp <= 12'h0001;
    wr(8'ha0);
    chk(12'(track), 12'h001, "not acquiring");
    cyc(300);
    chk(12'(track), 12'h001, "acquisition ended early");
    wr(8'ha0);
    wait_done();
    rd();
    idle();
    $display("test external acquisition done");
    wr(8'h00);
    cyc(300);
    chk(12'(dn), 12'h001, "power-down converted");
    chk(12'(cfg), 12'h000, "power-down config");
    idle();
    $display("test power-down done");
    summarize();
  end
endmodule
